// >>> hw/pfcp_port.sv
// Purpose: command front end of a paged flash with a byte-wide port
// Assumes: host drives cs_n, link clock and data; all pins oversampled
// Notes:   decodes opcode and address bytes, reports busy, one byte per link clock cycle
//
// Functional notes
// - accepts commands with either idle clock level
// - bytes captured on rising link clock edge
// - one full byte per link clock cycle
// - opcode first, then address bytes
// - status read needs opcode only
// - page read opcode carries split page address
// - buffer read/write opcodes ignore page bits
// - transfer and compare opcodes use page layout
// - buffer write and program sequences supported
// - polarity sampled at cs fall, reset idle-high
// - busy low during self-timed operations
`timescale 1ns/1ps
module pfcp_port
#(
  parameter int BUSY_XFER = 3000,
  parameter int BUSY_PROG = 175000
)
(
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic               reset_n_pin,
  input  wire logic               cs_n,
  input  wire logic               link_clk,
  input  wire logic [7:0]         parallel_data_lines_i,
  output logic      [7:0]         parallel_data_lines_o,
  output logic                    parallel_data_lines_oe_n,
  output logic                    ready_busy_o,
  output logic                    ready_busy_oe_n,
  output logic                    clk_pol_idle_high,
  output logic                    cmd_valid,
  output pfcp_pkg::pfcp_frame_t   cmd_frame,
  output logic                    data_valid,
  output logic      [7:0]         data_byte,
  input  wire logic [7:0]         rd_byte,
  input  wire logic [7:0]         status_byte,
  output logic                    busy_buf_sel
);

  if (BUSY_XFER < 1 || BUSY_PROG < 1 || BUSY_XFER > 32'h0003FFFF || BUSY_PROG > 32'h0003FFFF)
  begin : g_bad_busy
    $error("busy counts must fit the 18-bit timer");
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [10:0] pins_s;
  pfcp_sync #(.WIDTH(11)) u_sync
  (
    .clock   (clock),
    .rst     (rst),
    .d       ({reset_n_pin, cs_n, link_clk, parallel_data_lines_i}),
    .rst_val ({1'b1, 1'b1, pfcp_pkg::CLK_POL_RESET, 8'h00}),
    .q       (pins_s)
  );

  wire       rstp_n_s = pins_s[10];
  wire       cs_n_s   = pins_s[9];
  wire       lclk_s   = pins_s[8];
  wire [7:0] din_s    = pins_s[7:0];

  ////////////////////////////////////////////////////////////////////////
  // edge detection
  logic cs_n_d_r;
  logic lclk_d_r;
  logic [7:0] din_d_r;
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cs_n_d_r <= 1'b1;
      lclk_d_r <= pfcp_pkg::CLK_POL_RESET;
      din_d_r  <= 8'h00;
    end
    else
    begin
      cs_n_d_r <= cs_n_s;
      lclk_d_r <= lclk_s;
      din_d_r  <= din_s;
    end
  end

  wire cs_fall   = cs_n_d_r & ~cs_n_s;
  wire cs_rise   = ~cs_n_d_r & cs_n_s;
  // first rising edge after cs fall in idle-low mode is a real edge;
  // in idle-high mode the first fall then rise carries byte one
  wire lclk_rise = ~lclk_d_r & lclk_s & ~cs_n_s;
  wire lclk_fall = lclk_d_r & ~lclk_s & ~cs_n_s;
  wire soft_rst  = ~rstp_n_s;

  ////////////////////////////////////////////////////////////////////////
  // polarity mode
  logic pol_r;
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      pol_r <= pfcp_pkg::CLK_POL_RESET;
    else if (soft_rst)
      pol_r <= pfcp_pkg::CLK_POL_RESET;
    else if (cs_fall)
      pol_r <= lclk_s;
  end
  assign clk_pol_idle_high = pol_r;

  ////////////////////////////////////////////////////////////////////////
  // opcode decode
  wire [7:0] opc = din_d_r;
  pfcp_pkg::pfcp_cmd_t dec_cmd;
  wire dec_buf;
  assign dec_buf =
    (opc == pfcp_pkg::OP_BUF2_READ)  || (opc == pfcp_pkg::OP_XFER_B2) ||
    (opc == pfcp_pkg::OP_CMP_B2)     || (opc == pfcp_pkg::OP_BUF2_WRITE) ||
    (opc == pfcp_pkg::OP_PROG_B2)    || (opc == pfcp_pkg::OP_MMPROG_B2);
  assign dec_cmd =
    (opc == pfcp_pkg::OP_PAGE_READ)                                     ? pfcp_pkg::PFCP_C_PREAD :
    (opc == pfcp_pkg::OP_BUF1_READ  || opc == pfcp_pkg::OP_BUF2_READ)   ? pfcp_pkg::PFCP_C_BREAD :
    (opc == pfcp_pkg::OP_XFER_B1    || opc == pfcp_pkg::OP_XFER_B2)     ? pfcp_pkg::PFCP_C_XFER :
    (opc == pfcp_pkg::OP_CMP_B1     || opc == pfcp_pkg::OP_CMP_B2)      ? pfcp_pkg::PFCP_C_CMP :
    (opc == pfcp_pkg::OP_BUF1_WRITE || opc == pfcp_pkg::OP_BUF2_WRITE)  ? pfcp_pkg::PFCP_C_BWRITE :
    (opc == pfcp_pkg::OP_PROG_B1    || opc == pfcp_pkg::OP_PROG_B2)     ? pfcp_pkg::PFCP_C_PROG :
    (opc == pfcp_pkg::OP_MMPROG_B1  || opc == pfcp_pkg::OP_MMPROG_B2)   ? pfcp_pkg::PFCP_C_MMPROG :
    (opc == pfcp_pkg::OP_STATUS)                                        ? pfcp_pkg::PFCP_C_STATUS :
                                                                          pfcp_pkg::PFCP_C_NONE;

  ////////////////////////////////////////////////////////////////////////
  // frame sequencer
  pfcp_pkg::pfcp_state_t state_r;
  pfcp_pkg::pfcp_state_t state_nxt;
  pfcp_pkg::pfcp_frame_t frame_r;
  logic [1:0]  addr_cnt_r;
  logic        busy_r;
  logic        busy_buf_r;
  logic [17:0] busy_cnt_r;
  logic        cmd_valid_r;
  logic        data_valid_r;
  logic [7:0]  data_r;
  logic [7:0]  dout_r;
  logic        oe_r;

  wire byte_strobe = lclk_rise;
  wire last_addr   = (addr_cnt_r == 2'(pfcp_pkg::ADDR_BYTES - 1));
  wire reads_out   = (frame_r.cmd == pfcp_pkg::PFCP_C_PREAD) || (frame_r.cmd == pfcp_pkg::PFCP_C_BREAD);
  wire writes_in   = (frame_r.cmd == pfcp_pkg::PFCP_C_BWRITE) || (frame_r.cmd == pfcp_pkg::PFCP_C_MMPROG);
  wire self_timed  = (frame_r.cmd == pfcp_pkg::PFCP_C_XFER) || (frame_r.cmd == pfcp_pkg::PFCP_C_CMP) ||
                     (frame_r.cmd == pfcp_pkg::PFCP_C_PROG) || (frame_r.cmd == pfcp_pkg::PFCP_C_MMPROG);
  wire [17:0] busy_len = ((frame_r.cmd == pfcp_pkg::PFCP_C_XFER) || (frame_r.cmd == pfcp_pkg::PFCP_C_CMP))
                       ? 18'(BUSY_XFER) : 18'(BUSY_PROG);
  // array busy blocks every command except status and buffer read/write using the other buffer
  wire other_buf   = (frame_r.cmd == pfcp_pkg::PFCP_C_BREAD || frame_r.cmd == pfcp_pkg::PFCP_C_BWRITE) &&
                     (frame_r.buf_sel != busy_buf_r);
  wire blocked     = busy_r & ~other_buf & (frame_r.cmd != pfcp_pkg::PFCP_C_STATUS);
  wire launch      = cs_rise & (state_r == pfcp_pkg::PFCP_DATA || state_r == pfcp_pkg::PFCP_WAIT) &
                     self_timed & ~blocked;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      pfcp_pkg::PFCP_IDLE: if (cs_fall) state_nxt = pfcp_pkg::PFCP_OPC;
      pfcp_pkg::PFCP_OPC:
        if (byte_strobe)
          state_nxt = (dec_cmd == pfcp_pkg::PFCP_C_STATUS) ? pfcp_pkg::PFCP_STAT : pfcp_pkg::PFCP_ADDR;
      pfcp_pkg::PFCP_ADDR: if (byte_strobe && last_addr) state_nxt = pfcp_pkg::PFCP_DATA;
      pfcp_pkg::PFCP_DATA: state_nxt = state_r;
      pfcp_pkg::PFCP_STAT: state_nxt = state_r;
      pfcp_pkg::PFCP_WAIT: state_nxt = state_r;
      default:             state_nxt = pfcp_pkg::PFCP_IDLE;
    endcase
    if (cs_rise || soft_rst)
      state_nxt = pfcp_pkg::PFCP_IDLE;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      state_r <= pfcp_pkg::PFCP_IDLE;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      frame_r    <= '0;
      addr_cnt_r <= 2'h0;
    end
    else if (state_r == pfcp_pkg::PFCP_OPC && byte_strobe)
    begin
      frame_r.cmd     <= dec_cmd;
      frame_r.buf_sel <= dec_buf;
      addr_cnt_r      <= 2'h0;
    end
    else if (state_r == pfcp_pkg::PFCP_ADDR && byte_strobe)
    begin
      addr_cnt_r <= addr_cnt_r + 2'h1;
      if (addr_cnt_r == 2'h0)
      begin
        frame_r.byte2                    <= din_d_r;
        frame_r.page_addr[11:7]          <= din_d_r[pfcp_pkg::PA_HI_LSB +: pfcp_pkg::PA_HI_W];
      end
      else if (addr_cnt_r == 2'h1)
      begin
        frame_r.byte3                    <= din_d_r;
        frame_r.page_addr[6:4]           <= din_d_r[pfcp_pkg::PA_LO_LSB +: pfcp_pkg::PA_LO_W];
      end
      else
        frame_r.page_addr[3:0]           <= frame_r.byte3[pfcp_pkg::PA_BOT_LSB +: pfcp_pkg::PA_BOT_W];
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cmd_valid_r  <= 1'b0;
      data_valid_r <= 1'b0;
      data_r       <= 8'h00;
    end
    else
    begin
      cmd_valid_r  <= (state_r == pfcp_pkg::PFCP_ADDR) & byte_strobe & last_addr & ~blocked;
      data_valid_r <= (state_r == pfcp_pkg::PFCP_DATA) & byte_strobe & writes_in & ~blocked;
      if ((state_r == pfcp_pkg::PFCP_DATA) & byte_strobe)
        data_r <= din_d_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output drive, changes on the falling link edge
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      dout_r <= 8'h00;
      oe_r   <= 1'b0;
    end
    else if (soft_rst || cs_n_s)
    begin
      dout_r <= 8'h00;
      oe_r   <= 1'b0;
    end
    else if (lclk_fall && state_r == pfcp_pkg::PFCP_STAT)
    begin
      dout_r <= status_byte;
      oe_r   <= 1'b1;
    end
    else if (lclk_fall && state_r == pfcp_pkg::PFCP_DATA && reads_out && !blocked)
    begin
      dout_r <= rd_byte;
      oe_r   <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // busy timer
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      busy_r     <= 1'b0;
      busy_buf_r <= 1'b0;
      busy_cnt_r <= 18'h00000;
    end
    else if (soft_rst)
    begin
      busy_r     <= 1'b0;
      busy_cnt_r <= 18'h00000;
    end
    else if (launch)
    begin
      busy_r     <= 1'b1;
      busy_buf_r <= frame_r.buf_sel;
      busy_cnt_r <= busy_len;
    end
    else if (busy_r)
    begin
      busy_cnt_r <= busy_cnt_r - 18'h00001;
      if (busy_cnt_r == 18'h00001)
        busy_r <= 1'b0;
    end
  end

  assign parallel_data_lines_o    = dout_r;
  assign parallel_data_lines_oe_n = ~oe_r;
  assign ready_busy_o             = 1'b0;
  assign ready_busy_oe_n          = ~busy_r;
  assign cmd_valid                = cmd_valid_r;
  assign cmd_frame                = frame_r;
  assign data_valid               = data_valid_r;
  assign data_byte                = data_r;
  assign busy_buf_sel             = busy_buf_r;

endmodule // pfcp_port

// >>> hw/pfcp_pkg.sv
// Purpose: shared constants and types of the paged flash command port
// Assumes: byte-wide pins oversampled by the system clock
// Notes:   opcode values and address field positions of the command frame
package pfcp_pkg;

  localparam logic [7:0] OP_PAGE_READ  = 8'h52;
  localparam logic [7:0] OP_XFER_B1    = 8'h53;
  localparam logic [7:0] OP_BUF1_READ  = 8'h54;
  localparam logic [7:0] OP_XFER_B2    = 8'h55;
  localparam logic [7:0] OP_BUF2_READ  = 8'h56;
  localparam logic [7:0] OP_CMP_B1     = 8'h60;
  localparam logic [7:0] OP_CMP_B2     = 8'h61;
  localparam logic [7:0] OP_BUF1_WRITE = 8'h84;
  localparam logic [7:0] OP_BUF2_WRITE = 8'h87;
  localparam logic [7:0] OP_PROG_B1    = 8'h83;
  localparam logic [7:0] OP_PROG_B2    = 8'h86;
  localparam logic [7:0] OP_MMPROG_B1  = 8'h82;
  localparam logic [7:0] OP_MMPROG_B2  = 8'h85;
  localparam logic [7:0] OP_STATUS     = 8'h57;

  // page address field positions in bytes two and three
  localparam int PA_HI_LSB   = 0;
  localparam int PA_HI_W     = 5;
  localparam int PA_LO_LSB   = 5;
  localparam int PA_LO_W     = 3;
  localparam int PA_BOT_LSB  = 1;
  localparam int PA_BOT_W    = 4;
  localparam int ADDR_BYTES  = 3;

  localparam logic CLK_POL_RESET  = 1'b1;
  localparam int   BUSY_CYCLES    = 8;
  localparam int   SYNC_STAGES    = 2;

  typedef enum logic [2:0]
  {
    PFCP_IDLE = 3'b000,
    PFCP_OPC  = 3'b001,
    PFCP_ADDR = 3'b010,
    PFCP_DATA = 3'b011,
    PFCP_STAT = 3'b100,
    PFCP_WAIT = 3'b101
  } pfcp_state_t;

  typedef enum logic [3:0]
  {
    PFCP_C_NONE   = 4'h0,
    PFCP_C_PREAD  = 4'h1,
    PFCP_C_BREAD  = 4'h2,
    PFCP_C_XFER   = 4'h3,
    PFCP_C_CMP    = 4'h4,
    PFCP_C_BWRITE = 4'h5,
    PFCP_C_PROG   = 4'h6,
    PFCP_C_MMPROG = 4'h7,
    PFCP_C_STATUS = 4'h8
  } pfcp_cmd_t;

  typedef struct packed
  {
    pfcp_cmd_t   cmd;
    logic        buf_sel;
    logic [11:0] page_addr;
    logic [7:0]  byte2;
    logic [7:0]  byte3;
  } pfcp_frame_t;

endpackage

// >>> hw/pfcp_sync.sv
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs asynchronous to clock
// Notes:   first stage read only by the second
`timescale 1ns/1ps
module pfcp_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  input  wire logic [WIDTH-1:0] rst_val,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] q_r;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("pfcp_sync width must be positive");
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= '0;
      q_r    <= '0;
    end
    else
    begin
      meta_r <= d;
      q_r    <= meta_r;
    end
  end

  // idle value shown until the second stage holds a real sample
  logic [1:0] seen_r;
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      seen_r <= 2'b00;
    else
      seen_r <= {seen_r[0], 1'b1};
  end

  assign q = seen_r[1] ? q_r : rst_val;

endmodule // pfcp_sync

// >>> tb/pfcp_port_monitor.sv
// Purpose: port assertions of the flash command port
// Assumes: one clock domain, reset rst
// Notes:   sim busy counts well above 8
`timescale 1ns/1ps
module pfcp_port_monitor
(
  input logic                  clock,
  input logic                  rst,
  input logic                  reset_n_pin,
  input logic                  cs_n,
  input logic                  parallel_data_lines_oe_n,
  input logic                  ready_busy_o,
  input logic                  ready_busy_oe_n,
  input logic                  clk_pol_idle_high,
  input logic                  cmd_valid,
  input pfcp_pkg::pfcp_frame_t cmd_frame,
  input logic                  data_valid,
  input logic                  busy_buf_sel
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_pol_after_rst: assert property ($past(rst) |-> clk_pol_idle_high)
    else $error("polarity not high after reset");
  a_pol_hold_cs: assert property ((!cs_n && reset_n_pin) [*6] |-> $stable(clk_pol_idle_high))
    else $error("polarity moved in frame");
  a_oe_off_idle: assert property (cs_n [*5] |-> parallel_data_lines_oe_n)
    else $error("data driven while idle");
  a_cmd_one_pulse: assert property (cmd_valid |=> !cmd_valid)
    else $error("command pulse too long");
  a_data_one_pulse: assert property (data_valid |=> !data_valid)
    else $error("data pulse too long");
  a_page_split: assert property (cmd_valid && cmd_frame.cmd inside {pfcp_pkg::PFCP_C_PREAD,
    pfcp_pkg::PFCP_C_XFER, pfcp_pkg::PFCP_C_CMP} |-> cmd_frame.page_addr[11:7] == cmd_frame.byte2[4:0]
    && cmd_frame.page_addr[6:4] == cmd_frame.byte3[7:5] && cmd_frame.page_addr[3:0] == cmd_frame.byte3[4:1])
    else $error("page address split wrong");
  a_busy_drive_low: assert property ($fell(ready_busy_oe_n) |-> ready_busy_o == 1'b0 &&
    cmd_frame.cmd inside {pfcp_pkg::PFCP_C_XFER, pfcp_pkg::PFCP_C_CMP, pfcp_pkg::PFCP_C_PROG,
    pfcp_pkg::PFCP_C_MMPROG})
    else $error("busy without self-timed command");
  a_busy_refuse: assert property (cmd_valid && !ready_busy_oe_n
    |-> cmd_frame.cmd inside {pfcp_pkg::PFCP_C_BREAD, pfcp_pkg::PFCP_C_BWRITE} && cmd_frame.buf_sel != busy_buf_sel)
    else $error("command accepted while busy");
  a_busy_min_len: assert property ($fell(ready_busy_oe_n) |=> (!ready_busy_oe_n || !reset_n_pin) [*8])
    else $error("busy too short");
endmodule // pfcp_port_monitor

bind pfcp_port pfcp_port_monitor i_pfcp_port_monitor
(
  .clock                    (clock),
  .rst                      (rst),
  .reset_n_pin              (reset_n_pin),
  .cs_n                     (cs_n),
  .parallel_data_lines_oe_n (parallel_data_lines_oe_n),
  .ready_busy_o             (ready_busy_o),
  .ready_busy_oe_n          (ready_busy_oe_n),
  .clk_pol_idle_high        (clk_pol_idle_high),
  .cmd_valid                (cmd_valid),
  .cmd_frame                (cmd_frame),
  .data_valid               (data_valid),
  .busy_buf_sel             (busy_buf_sel)
);

// >>> tb/pfcp_host.sv
// Purpose: host controller model of the byte port
// Assumes: PH clocks per link clock phase
// Notes:   released data lines toggle every clock
`timescale 1ns/1ps
module pfcp_host
#(
  parameter int PH = 6
)
(
  input  logic       clock,
  input  logic [7:0] d_in,
  output logic       cs_n,
  output logic       link_clk,
  output logic [7:0] d,
  output logic       en
);
  logic [7:0] d_r;
  logic [7:0] float_r = 8'h00;
  // released lines show a changing value, never the last byte
  assign d = en ? d_r : float_r;
  always @(posedge clock)
    float_r <= ~float_r;
  task automatic idle;
    cs_n = 1'b1;
    link_clk = 1'b1;
    d_r = 8'h00;
    en = 1'b0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // idle level set before cs_n falls
  task automatic begin_cmd(input logic pol);
    link_clk = pol;
    wt(PH);
    cs_n = 1'b0;
    wt(PH);
  endtask
  // byte held across the rising edge
  task automatic put(input logic [7:0] b);
    link_clk = 1'b0;
    d_r = b;
    en = 1'b1;
    wt(PH);
    link_clk = 1'b1;
    wt(PH);
  endtask
  task automatic get(output logic [7:0] b);
    en = 1'b0;
    link_clk = 1'b0;
    wt(PH);
    b = d_in;
    link_clk = 1'b1;
    wt(PH);
  endtask
  // release the lines first: a read may drive them on this link edge
  task automatic end_cmd(input logic pol);
    en = 1'b0;
    link_clk = pol;
    wt(PH);
    cs_n = 1'b1;
    wt(2 * PH);
  endtask
endmodule // pfcp_host

// >>> tb/pfcp_port_tb.sv
// Purpose: self-checking bench of the flash command port
// Assumes: busy counts shortened to 400 and 800
// Notes:   read and status values set per scenario
`timescale 1ns/1ps
module pfcp_port_tb;
  logic                  clock;
  logic                  rst;
  logic                  reset_n_pin;
  logic                  cs_n;
  logic                  link_clk;
  logic [7:0]            h_d;
  logic [7:0]            pins;
  logic [7:0]            pdl_o;
  logic                  oe_n;
  logic                  rb_oe_n;
  logic                  pol;
  logic                  cmd_valid;
  pfcp_pkg::pfcp_frame_t cmd_frame;
  pfcp_pkg::pfcp_frame_t frm;
  logic                  data_valid;
  logic [7:0]            data_byte;
  logic [7:0]            last_data;
  logic                  bsy_sel;
  int                    n_cmd = 0;
  int                    n_data = 0;
  int                    c0;
  logic [7:0]            rd_val = 8'hC3;
  logic [7:0]            stat_val = 8'h3C;
  logic [7:0]            rx;
  int                    n_mismatch;
  int                    check_count;

  assign pins = oe_n ? h_d : pdl_o;
  pfcp_host i_pfcp_host (.clock(clock), .d_in(pins), .cs_n(cs_n), .link_clk(link_clk), .d(h_d), .en());
  pfcp_port #(.BUSY_XFER(400), .BUSY_PROG(800)) i_pfcp_port
  (
    .clock(clock), .rst(rst), .reset_n_pin(reset_n_pin), .cs_n(cs_n), .link_clk(link_clk),
    .parallel_data_lines_i(pins), .parallel_data_lines_o(pdl_o), .parallel_data_lines_oe_n(oe_n),
    .ready_busy_o(), .ready_busy_oe_n(rb_oe_n), .clk_pol_idle_high(pol), .cmd_valid(cmd_valid),
    .cmd_frame(cmd_frame), .data_valid(data_valid), .data_byte(data_byte), .rd_byte(rd_val),
    .status_byte(stat_val), .busy_buf_sel(bsy_sel)
  );
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock)
  begin
    if (cmd_valid)
    begin
      n_cmd   <= n_cmd + 1;
      frm     <= cmd_frame;
    end
    if (data_valid)
    begin
      n_data    <= n_data + 1;
      last_data <= data_byte;
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic frame(input logic [7:0] op, input logic [7:0] b2, input logic p);
    c0 = n_cmd;
    i_pfcp_host.begin_cmd(p);
    i_pfcp_host.put(op);
    i_pfcp_host.put(b2);
    i_pfcp_host.put(8'hA6);
    i_pfcp_host.put(8'h00);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic s_opcodes;
    logic [7:0]          ops [9];
    pfcp_pkg::pfcp_cmd_t cmds [9];
    logic [8:0]          bsel;
    logic [8:0]          pg;
    logic [8:0]          st;
    ops = '{8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h60, 8'h61, 8'h84, 8'h87};
    cmds = '{pfcp_pkg::PFCP_C_PREAD, pfcp_pkg::PFCP_C_XFER, pfcp_pkg::PFCP_C_BREAD, pfcp_pkg::PFCP_C_XFER,
      pfcp_pkg::PFCP_C_BREAD, pfcp_pkg::PFCP_C_CMP, pfcp_pkg::PFCP_C_CMP, pfcp_pkg::PFCP_C_BWRITE,
      pfcp_pkg::PFCP_C_BWRITE};
    bsel = 9'h158;
    pg = 9'h06B;
    st = 9'h06A;
    for (int i = 0; i < 9; i++)
    begin
      frame(ops[i], 8'h15, i[0]);
      i_pfcp_host.end_cmd(i[0]);
      check("cmd_seen", 16'(n_cmd - c0), 16'h0001);
      check("cmd_kind", frm.cmd, cmds[i]);
      check("polarity", pol, i[0]);
      if (i > 0)
        check("buf_sel", frm.buf_sel, bsel[i]);
      if (pg[i])
        check("page", frm.page_addr, 12'hAD3);
      check("busy_start", rb_oe_n, !st[i]);
      if (st[i])
      begin
        i_pfcp_host.wt(360);
        check("busy_hold", rb_oe_n, 1'b0);
        i_pfcp_host.wt(60);
        check("busy_end", rb_oe_n, 1'b1);
      end
    end
  endtask
  task automatic s_read_status;
    rd_val = 8'h5A;
    stat_val = 8'hA5;
    frame(8'h52, 8'h15, 1'b0);
    i_pfcp_host.get(rx);
    check("read_byte", rx, 8'h5A);
    check("oe_read", oe_n, 1'b0);
    i_pfcp_host.end_cmd(1'b0);
    check("oe_idle", oe_n, 1'b1);
    i_pfcp_host.begin_cmd(1'b1);
    i_pfcp_host.put(8'h57);
    i_pfcp_host.get(rx);
    check("status", rx, 8'hA5);
    i_pfcp_host.end_cmd(1'b1);
  endtask
  task automatic s_abort;
    c0 = n_cmd;
    i_pfcp_host.begin_cmd(1'b0);
    i_pfcp_host.put(8'h52);
    i_pfcp_host.put(8'h15);
    i_pfcp_host.end_cmd(1'b0);
    check("abort", 16'(n_cmd - c0), 16'h0000);
    frame(8'h54, 8'h00, 1'b0);
    i_pfcp_host.end_cmd(1'b0);
    check("after_abort", 16'(n_cmd - c0), 16'h0001);
    check("after_kind", frm.cmd, pfcp_pkg::PFCP_C_BREAD);
  endtask
  // other buffer stays usable while busy
  task automatic s_busy;
    int d0;
    frame(8'h53, 8'h15, 1'b1);
    i_pfcp_host.end_cmd(1'b1);
    check("busy_buf", bsy_sel, 1'b0);
    d0 = n_data;
    frame(8'h87, 8'h00, 1'b1);
    i_pfcp_host.put(8'h9E);
    i_pfcp_host.put(8'h61);
    check("other_buf", frm.cmd, pfcp_pkg::PFCP_C_BWRITE);
    i_pfcp_host.end_cmd(1'b1);
    check("data_count", 16'(n_data - d0), 16'h0002);
    check("data_byte", last_data, 8'h61);
    frame(8'h52, 8'h15, 1'b0);
    i_pfcp_host.end_cmd(1'b0);
    check("refused", 16'(n_cmd - c0), 16'h0000);
    reset_n_pin = 1'b0;
    i_pfcp_host.wt(6);
    check("pin_busy", rb_oe_n, 1'b1);
    check("pin_pol", pol, 1'b1);
    reset_n_pin = 1'b1;
    i_pfcp_host.wt(6);
    frame(8'h52, 8'h15, 1'b1);
    i_pfcp_host.end_cmd(1'b1);
    check("after_pin", 16'(n_cmd - c0), 16'h0001);
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    i_pfcp_host.idle();
    rst = 1'b1;
    reset_n_pin = 1'b1;
    n_mismatch = 0;
    check_count = 0;
    repeat (4) @(posedge clock);
    #1;
    rst = 1'b0;
    i_pfcp_host.wt(3);
    check("pol_reset", pol, 1'b1);
    s_opcodes();
    s_read_status();
    s_abort();
    s_busy();
    final_report();
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    final_report();
  end
endmodule // pfcp_port_tb
